// file: src/aij_pkg.sv
/*
  Constants, field layout and carrier types of the auto index jump unit.
  Assumes a main memory of ADDR_W address bits that answers one access
  per machine cycle on the same clock as the unit.
*/
// Operation
// RQ1: Only low memory words 0..37 octal used
// RQ2: Address field selects location and variant
// RQ3: Increment adds one, wraps, writes back
// RQ4: Increment variant jumps when sum zero
// RQ5: Three cycles plain, four with jump
// RQ6: Increment nonzero variant jumps on nonzero sum
// RQ7: Increment sets overflow on signed wrap
// RQ8: Decrement subtracts one, wraps, writes back
// RQ9: Decrement variant jumps when difference zero
// RQ10: Decrement nonzero variant jumps on nonzero
// RQ11: Decrement nonzero timing, extra cycle optional
// RQ12: Decrement sets overflow on signed wrap
// RQ13: Only location, counter and overflow change
// RQ14: No indexing, indirect jump address honoured
// RQ15: Opcode 00, mode 7, variant, base 40
// RQ16: Jump word follows; fall through skips it
// RQ17: Zero test uses newly stored value
package aij_pkg;

  // ****************************************************************
  // Word and field layout
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int ADDR_W = 15;
  localparam int OP_LSB = 12;
  localparam int M_MSB = 11;
  localparam int M_LSB = 9;
  localparam logic [2:0] M_AUTO = 3'h7;
  localparam int VAR_MSB = 8;
  localparam int VAR_LSB = 6;
  localparam int BASE_POS = 5;
  localparam int LOC_MSB = 4;
  localparam int IND_POS = 15;
  localparam logic [ADDR_W-1:0] PC_STEP = 15'h0001;
  localparam logic [ADDR_W-1:0] PC_SKIP = 15'h0002;
  localparam logic [WORD_W-1:0] ONE = 16'h0001;
  localparam logic [WORD_W-1:0] ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] SIGN_MIN = 16'h8000;
  localparam logic [WORD_W-1:0] SIGN_MAX = 16'h7FFF;

  // ****************************************************************
  // Timing in machine cycles
  // ****************************************************************
  localparam int CYC_W = 5;
  localparam logic [CYC_W-1:0] CYC_FETCH = 5'h01;
  localparam logic [CYC_W-1:0] CYC_ONE = 5'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    INC_BRANCH_ZERO,
    INC_BRANCH_NONZERO,
    DEC_BRANCH_ZERO,
    DEC_BRANCH_NONZERO
  } aij_var_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_LOC,
    ST_WR_LOC,
    ST_RD_JUMP,
    ST_PAD
  } aij_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } aij_mem_req_s;

  typedef struct packed {
    logic ack;
    logic [WORD_W-1:0] rdata;
  } aij_mem_rsp_s;

  typedef struct packed {
    logic done;
    logic reject;
    logic set_overflow;
    logic jumped;
    logic [ADDR_W-1:0] next_pc;
    logic [CYC_W-1:0] cycles;
  } aij_result_s;

endpackage : aij_pkg

// file: src/aij_unit.sv
/*
  Execution unit of the auto index instruction group: increment or
  decrement a low memory word, write it back, and branch on zero or
  nonzero through an optionally indirect jump address word.
  Assumes the sequencer has fetched the instruction word and offers it
  with START; the unit holds MEM_REQ until memory raises ACK.
*/
`timescale 1ns/1ps

module aij_unit #(
  parameter bit DEC_NZ_EXTRA = 1'b0
) (
  input wire logic SYS_CLK, // System clock
  input wire logic RESET_N, // Asynchronous reset
  input wire logic START, // Instruction offered
  input wire logic [aij_pkg::WORD_W-1:0] INSTR, // First instruction word
  input wire logic [aij_pkg::ADDR_W-1:0] PC_IN, // Address of instruction
  input wire aij_pkg::aij_mem_rsp_s MEM_RSP, // Memory answer
  output aij_pkg::aij_mem_req_s MEM_REQ, // Memory request
  output aij_pkg::aij_result_s RESULT, // Completion report
  output logic BUSY // Instruction in progress
);
  import aij_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    aij_state_e st;
    aij_var_e vr;
    logic busy;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] loc_addr;
    logic [WORD_W-1:0] res;
    logic ovf;
    logic [CYC_W-1:0] cyc;
    aij_mem_req_s mem;
    aij_result_s out;
  } aij_regs_s;

  aij_regs_s r_r;
  aij_regs_s r_nxt;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic is_auto;
  logic [4:0] loc_field;
  aij_var_e var_field;
  logic is_dec;
  logic want_nonzero;
  logic [WORD_W-1:0] new_val;
  logic new_ovf;
  logic take_jump;
  logic pad_needed;

  always_comb begin
    // Opcode 00, mode 7, base bit, variant 0..3
    is_auto = (INSTR[WORD_W-1:OP_LSB] == '0) && // RQ15
              (INSTR[M_MSB:M_LSB] == M_AUTO) && // RQ15
              INSTR[BASE_POS] && // RQ15
              !INSTR[VAR_MSB]; // RQ15
    loc_field = INSTR[LOC_MSB:0]; // RQ1 RQ2
    var_field = aij_var_e'(INSTR[VAR_LSB+1:VAR_LSB]); // RQ2
    is_dec = (r_r.vr == DEC_BRANCH_ZERO) || (r_r.vr == DEC_BRANCH_NONZERO);
    want_nonzero = (r_r.vr == INC_BRANCH_NONZERO) ||
                   (r_r.vr == DEC_BRANCH_NONZERO);
    if (is_dec) begin
      new_val = MEM_RSP.rdata - ONE; // RQ8
      new_ovf = (MEM_RSP.rdata == SIGN_MIN); // RQ12
    end else begin
      new_val = MEM_RSP.rdata + ONE; // RQ3
      new_ovf = (MEM_RSP.rdata == SIGN_MAX); // RQ7
    end
    // Stored value drives the test
    if (want_nonzero) begin
      take_jump = (r_r.res != ZERO); // RQ6 RQ10 RQ17
    end else begin
      take_jump = (r_r.res == ZERO); // RQ4 RQ9 RQ17
    end
    pad_needed = DEC_NZ_EXTRA && (r_r.vr == DEC_BRANCH_NONZERO); // RQ11
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    r_nxt = r_r;
    r_nxt.out.done = 1'b0;
    r_nxt.out.reject = 1'b0;
    r_nxt.out.set_overflow = 1'b0;
    unique case (r_r.st)
      ST_IDLE: begin
        if (START) begin
          if (is_auto) begin
            r_nxt.vr = var_field; // RQ2
            r_nxt.pc = PC_IN;
            r_nxt.loc_addr = ADDR_W'(loc_field); // RQ1 RQ14
            r_nxt.busy = 1'b1;
            r_nxt.cyc = CYC_FETCH; // RQ5
            r_nxt.mem.req = 1'b1;
            r_nxt.mem.we = 1'b0;
            r_nxt.mem.addr = ADDR_W'(loc_field); // RQ1
            r_nxt.st = ST_RD_LOC;
          end else begin
            r_nxt.out.reject = 1'b1;
          end
        end
      end
      ST_RD_LOC: begin
        if (MEM_RSP.ack) begin
          r_nxt.res = new_val; // RQ3 RQ8
          r_nxt.ovf = new_ovf; // RQ7 RQ12
          r_nxt.cyc = r_r.cyc + CYC_ONE; // RQ5
          r_nxt.mem.we = 1'b1;
          r_nxt.mem.addr = r_r.loc_addr; // RQ3 RQ8 RQ13
          r_nxt.mem.wdata = new_val; // RQ3 RQ8
          r_nxt.st = ST_WR_LOC;
        end
      end
      ST_WR_LOC: begin
        if (MEM_RSP.ack) begin
          r_nxt.cyc = r_r.cyc + CYC_ONE; // RQ5
          r_nxt.mem.we = 1'b0;
          r_nxt.mem.wdata = '0;
          if (take_jump) begin
            r_nxt.mem.addr = r_r.pc + PC_STEP; // RQ16
            r_nxt.st = ST_RD_JUMP;
          end else begin
            r_nxt.mem.req = 1'b0;
            r_nxt.out.next_pc = r_r.pc + PC_SKIP; // RQ16
            r_nxt.out.jumped = 1'b0;
            if (pad_needed) begin
              r_nxt.st = ST_PAD; // RQ11
            end else begin
              r_nxt.out.done = 1'b1;
              r_nxt.out.set_overflow = r_r.ovf; // RQ7 RQ12 RQ13
              r_nxt.out.cycles = r_r.cyc + CYC_ONE; // RQ5
              r_nxt.busy = 1'b0;
              r_nxt.st = ST_IDLE;
            end
          end
        end
      end
      ST_RD_JUMP: begin
        if (MEM_RSP.ack) begin
          r_nxt.cyc = r_r.cyc + CYC_ONE; // RQ5
          if (MEM_RSP.rdata[IND_POS]) begin
            // Indirect chain: one more read per level
            r_nxt.mem.addr = MEM_RSP.rdata[ADDR_W-1:0]; // RQ14
          end else begin
            r_nxt.mem.req = 1'b0;
            r_nxt.out.next_pc = MEM_RSP.rdata[ADDR_W-1:0]; // RQ4 RQ6
            r_nxt.out.jumped = 1'b1;
            if (pad_needed) begin
              r_nxt.st = ST_PAD; // RQ11
            end else begin
              r_nxt.out.done = 1'b1;
              r_nxt.out.set_overflow = r_r.ovf; // RQ7 RQ12
              r_nxt.out.cycles = r_r.cyc + CYC_ONE; // RQ5
              r_nxt.busy = 1'b0;
              r_nxt.st = ST_IDLE;
            end
          end
        end
      end
      ST_PAD: begin
        // Extra machine cycle with no memory access
        r_nxt.out.done = 1'b1;
        r_nxt.out.set_overflow = r_r.ovf; // RQ12
        r_nxt.out.cycles = r_r.cyc + CYC_ONE; // RQ11
        r_nxt.busy = 1'b0;
        r_nxt.st = ST_IDLE;
      end
      default: begin
        r_nxt.st = ST_IDLE;
        r_nxt.busy = 1'b0;
        r_nxt.mem = '0;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_r <= '{st: ST_IDLE, vr: INC_BRANCH_ZERO, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign MEM_REQ = r_r.mem;
  assign RESULT = r_r.out;
  assign BUSY = r_r.busy;

endmodule : aij_unit

// file: dv/aij_unit_monitor.sv
/* Assertion checker of the auto index jump unit.
   Sees only the unit's ports; bound to every aij_unit instance. */
`timescale 1ns/1ps
module aij_unit_monitor #(
  parameter bit DEC_NZ_EXTRA = 1'b0
) (
  input wire logic SYS_CLK, // Clock
  input wire logic RESET_N, // Reset
  input wire logic START, // Offer
  input wire logic [aij_pkg::WORD_W-1:0] INSTR, // Word
  input wire logic [aij_pkg::ADDR_W-1:0] PC_IN, // Address
  input wire aij_pkg::aij_mem_rsp_s MEM_RSP, // Answer
  input wire aij_pkg::aij_mem_req_s MEM_REQ, // Request
  input wire aij_pkg::aij_result_s RESULT, // Report
  input wire logic BUSY // Busy
);
  import aij_pkg::*;
  // ******
  // Helper state
  // ******
  logic first_r, ovf_r;
  logic [1:0] var_r;
  logic [4:0] loc_r;
  logic [ADDR_W-1:0] pc_r;
  logic [WORD_W-1:0] exp_r;
  logic [CYC_W-1:0] acc_r;
  wire grp = INSTR[15:12] == 4'h0 && INSTR[11:9] == M_AUTO && !INSTR[8]
    && INSTR[5];
  wire take = START && !BUSY;
  wire pad = DEC_NZ_EXTRA && var_r == 2'h3;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      first_r <= 1'b0;
      ovf_r <= 1'b0;
      var_r <= 2'h0;
      loc_r <= 5'h00;
      pc_r <= '0;
      exp_r <= ZERO;
      acc_r <= '0;
    end else if (take) begin
      first_r <= grp;
      var_r <= INSTR[7:6];
      loc_r <= INSTR[4:0];
      pc_r <= PC_IN;
      acc_r <= '0;
    end else if (MEM_RSP.ack) begin
      acc_r <= acc_r + CYC_ONE;
      first_r <= 1'b0;
      if (first_r) begin
        exp_r <= var_r[1] ? MEM_RSP.rdata - ONE : MEM_RSP.rdata + ONE;
        ovf_r <= MEM_RSP.rdata == (var_r[1] ? SIGN_MIN : SIGN_MAX);
      end
    end
  end
  // ******
  // Properties
  // ******
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_first_rd;
    take && grp |=> MEM_REQ.req && !MEM_REQ.we
      && MEM_REQ.addr == ADDR_W'(loc_r);
  endproperty
  a_first_rd: assert property (p_first_rd)
    else $error("first access not a read of the location");
  property p_reject;
    take && !grp |=> RESULT.reject && !MEM_REQ.req && !RESULT.done;
  endproperty
  a_reject: assert property (p_reject)
    else $error("foreign word not refused");
  property p_wr_val;
    first_r && MEM_RSP.ack |=> MEM_REQ.req && MEM_REQ.we
      && MEM_REQ.wdata == exp_r;
  endproperty
  a_wr_val: assert property (p_wr_val)
    else $error("write back value wrong");
  property p_wr_loc;
    MEM_REQ.req && MEM_REQ.we |-> MEM_REQ.addr == ADDR_W'(loc_r);
  endproperty
  a_wr_loc: assert property (p_wr_loc)
    else $error("write outside selected location");
  property p_ovf;
    RESULT.done |-> RESULT.set_overflow == ovf_r;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow report wrong");
  property p_jump;
    RESULT.done |-> RESULT.jumped == (var_r[0] ^ (exp_r == ZERO));
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump decision wrong");
  property p_fall;
    RESULT.done && !RESULT.jumped |-> RESULT.next_pc == pc_r + PC_SKIP;
  endproperty
  a_fall: assert property (p_fall)
    else $error("fall through address wrong");
  property p_cyc;
    RESULT.done |-> RESULT.cycles == acc_r + CYC_FETCH + CYC_W'(pad);
  endproperty
  a_cyc: assert property (p_cyc)
    else $error("cycle count wrong");
endmodule : aij_unit_monitor

bind aij_unit aij_unit_monitor #(.DEC_NZ_EXTRA(DEC_NZ_EXTRA)) u_mon (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .START(START), .INSTR(INSTR),
  .PC_IN(PC_IN), .MEM_RSP(MEM_RSP), .MEM_REQ(MEM_REQ), .RESULT(RESULT),
  .BUSY(BUSY));

// file: dv/aij_mem_model.sv
/* Main memory partner: 128 words, answers at once or after one wait.
   Assumes the unit holds its request until the answer. */
`timescale 1ns/1ps
module aij_mem_model (
  input wire logic SYS_CLK, // Clock
  input wire logic RESET_N, // Reset
  input wire logic slow, // One wait cycle
  input wire aij_pkg::aij_mem_req_s mem_req, // Request
  output aij_pkg::aij_mem_rsp_s mem_rsp // Answer
);
  import aij_pkg::*;
  logic [WORD_W-1:0] mem [0:127];
  logic wait_r;
  logic [WORD_W-1:0] last_r;
  always_comb begin
    mem_rsp.ack = mem_req.req && (!slow || wait_r);
    // Stale data shown inverted
    mem_rsp.rdata = mem_rsp.ack ? mem[mem_req.addr[6:0]] : ~last_r;
  end
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_r <= 1'b0;
      last_r <= ZERO;
    end else begin
      wait_r <= mem_req.req && !mem_rsp.ack;
      last_r <= mem_rsp.rdata;
      if (mem_rsp.ack && mem_req.we) begin
        mem[mem_req.addr[6:0]] <= mem_req.wdata;
      end
    end
  end
endmodule : aij_mem_model

// file: dv/auto_index_jump_unit_bench.sv
/* Self-checking bench of the auto index jump unit.
   Memory partner behind the unit; checker bound to the unit. */
`timescale 1ns/1ps
module auto_index_jump_unit_bench;
  import aij_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [WORD_W-1:0] instr = ZERO;
  logic [ADDR_W-1:0] pc_in = 15'h0040;
  aij_mem_req_s mem_req;
  aij_mem_rsp_s mem_rsp;
  aij_result_s result;
  logic busy;
  aij_mem_req_s mem_req_p;
  aij_mem_rsp_s mem_rsp_p;
  aij_result_s result_p;
  logic busy_p;
  int num_errors = 0;
  int n_checks = 0;
  aij_unit dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .START(start),
    .INSTR(instr), .PC_IN(pc_in), .MEM_RSP(mem_rsp), .MEM_REQ(mem_req),
    .RESULT(result), .BUSY(busy));
  aij_mem_model mem (.SYS_CLK(sys_clk), .RESET_N(reset_n), .slow(slow),
    .mem_req(mem_req), .mem_rsp(mem_rsp));
  // Second unit with the extra decrement cycle, same stimulus
  aij_unit #(.DEC_NZ_EXTRA(1'b1)) dut_pad (.SYS_CLK(sys_clk),
    .RESET_N(reset_n), .START(start), .INSTR(instr), .PC_IN(pc_in),
    .MEM_RSP(mem_rsp_p), .MEM_REQ(mem_req_p), .RESULT(result_p),
    .BUSY(busy_p));
  aij_mem_model mem_p (.SYS_CLK(sys_clk), .RESET_N(reset_n), .slow(slow),
    .mem_req(mem_req_p), .mem_rsp(mem_rsp_p));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic offer(logic [15:0] w, bit rej);
    int i;
    @(posedge sys_clk);
    start <= 1'b1;
    instr <= w;
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if ((rej ? result.reject : result.done) === 1'b1) return;
      @(posedge sys_clk);
    end
    num_errors++;
    $display("Error completion expected 1 seen 0");
    print_verdict();
  endtask : offer
  task automatic op(logic [1:0] v, logic [4:0] loc, logic [15:0] old,
      logic [15:0] jw);
    logic [15:0] nw;
    logic jmp;
    logic [14:0] epc;
    logic eovf;
    int ecyc;
    nw = v[1] ? old - ONE : old + ONE;
    jmp = v[0] ^ (nw == ZERO);
    epc = !jmp ? 15'h0042 : jw[15] ? 15'h0066 : jw[14:0];
    eovf = old == (v[1] ? 16'h8000 : 16'h7FFF);
    ecyc = 3 + jmp + (jmp & jw[15]);
    mem.mem[loc] = old;
    mem.mem[7'h41] = jw;
    mem.mem[7'h50] = 16'h0066;
    mem_p.mem[loc] = old;
    mem_p.mem[7'h41] = jw;
    mem_p.mem[7'h50] = 16'h0066;
    offer({4'h0, M_AUTO, 1'b0, v, 1'b1, loc}, 1'b0);
    check("mem", mem.mem[loc], nw);
    check("jumped", result.jumped, jmp);
    check("pc", result.next_pc, epc);
    check("ovf", result.set_overflow, eovf);
    check("cyc", result.cycles, ecyc);
    // Padded unit finishes at most one cycle later
    @(posedge sys_clk) #1;
    check("mem_pad", mem_p.mem[loc], nw);
    check("pc_pad", result_p.next_pc, epc);
    check("cyc_pad", result_p.cycles, ecyc + (v == 2'h3));
    check("busy_pad", busy_p, 1'b0);
  endtask : op
  task automatic t_inc();
    op(2'h0, 5'h05, 16'hFFFF, 16'h0070);
    op(2'h0, 5'h05, 16'h0001, 16'h0070);
    op(2'h1, 5'h1F, 16'h7FFF, 16'h0070);
    op(2'h1, 5'h1F, 16'hFFFF, 16'h0070);
    $display("test inc done");
  endtask : t_inc
  task automatic t_dec();
    op(2'h2, 5'h00, 16'h0001, 16'h0070);
    op(2'h2, 5'h00, 16'h8000, 16'h0070);
    op(2'h3, 5'h0C, 16'h0001, 16'h0070);
    op(2'h3, 5'h0C, 16'h0000, 16'h0070);
    $display("test dec done");
  endtask : t_dec
  task automatic t_slow();
    @(posedge sys_clk);
    slow <= 1'b1;
    op(2'h3, 5'h07, 16'h0005, 16'h8050);
    op(2'h0, 5'h07, 16'hFFFF, 16'h8050);
    @(posedge sys_clk);
    slow <= 1'b0;
    $display("test slow indirect done");
  endtask : t_slow
  task automatic t_rej();
    offer(16'h1E25, 1'b1);
    check("req", mem_req.req, 1'b0);
    offer(16'h0E05, 1'b1);
    check("busy", busy, 1'b0);
    $display("test reject done");
  endtask : t_rej
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_inc();
    t_dec();
    t_slow();
    t_rej();
    print_verdict();
  end
endmodule : auto_index_jump_unit_bench
